// [hdl/nibble_exec.sv]
// execution datapath for rotate right, return and subtract-with-borrow
// Function
// - rotate right: carry into bit 3, bit 0 out
// - rotate decode, one cycle, memory and accumulator
// - return reloads 11-bit counter from stack top
// - memory minus accumulator minus carry, accumulator only
// - register minus immediate minus carry, accumulator only
// - memory subtract result to accumulator and memory
// - register subtract result to accumulator and register
`timescale 1ns/100ps
module nibble_exec (
   // clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       sys_rst,
   // instruction from decoder
   input  wire logic                       instr_valid,
   input  wire logic [nibble_pkg::INSTR_W-1:0] instr,
   // operands fetched for this instruction
   input  wire logic [nibble_pkg::NIB_W-1:0]  mem_rdata,
   input  wire logic [nibble_pkg::NIB_W-1:0]  wreg_rdata,
   input  wire logic [nibble_pkg::PC_W-1:0]   stack_top,
   // data memory write
   output logic                            mem_we_r,
   output logic [nibble_pkg::ADDR_W-1:0]   mem_addr_r,
   output logic [nibble_pkg::NIB_W-1:0]    mem_wdata_r,
   // working register write
   output logic                            wreg_we_r,
   output logic [nibble_pkg::WSEL_W-1:0]   wreg_sel_r,
   output logic [nibble_pkg::NIB_W-1:0]    wreg_wdata_r,
   // program counter load and stack pop
   output logic                            pc_load_r,
   output logic [nibble_pkg::PC_W-1:0]     pc_value_r,
   // architectural state
   output logic [nibble_pkg::NIB_W-1:0]    result_nibble_register_r,
   output logic                            carry_bit_r,
   output logic                            zero_bit_r
);
   import nibble_pkg::*;

   // word layout handled here, bit 15 first:
   //   rotate right      9-bit prefix, then a 7-bit memory address
   //   subtract memory   9-bit prefix, then a 7-bit memory address
   //   subtract store    9-bit prefix, then a 7-bit memory address
   //   subtract register 8-bit prefix, immediate [7:4], select [3:0]
   //   subtract reg st   8-bit prefix, immediate [7:4], select [3:0]
   //   return            7-bit prefix, the low bits are ignored
   // any other word, or a word without instr_valid, leaves all state
   // as it was and raises no strobe.
   //
   // the environment answers reads in the same cycle, so every form
   // here retires in one clock; a store is presented one cycle late,
   // and the environment must forward a pending store to a read of
   // the same location in that cycle.

   alu_if au ();

   nibble_alu u_alu (
      .a (au.unit)
   );

   // prefix match of width n against the top of the instruction
   function automatic logic match(input logic [15:0] word,
                                  input logic [8:0]  pfx,
                                  input int          n);
      logic [8:0] top;
      top = 9'(word >> (16 - n));
      return top == (pfx & 9'((1 << n) - 1));
   endfunction

   logic is_rot;
   logic is_sub_m;
   logic is_sub_ms;
   logic is_sub_i;
   logic is_sub_is;
   logic is_ret;

   // decode; only one prefix can hit for any word
   always_comb begin
      is_rot    = instr_valid && match(instr, OP_ROTATE_RIGHT, 9);
      is_sub_m  = instr_valid && match(instr, OP_SUB_MEM, 9);
      is_sub_ms = instr_valid && match(instr, OP_SUB_MEM_ST, 9);
      is_sub_i  = instr_valid && match(instr, {1'b0, OP_SUB_IMM}, 8);
      is_sub_is = instr_valid && match(instr, {1'b0, OP_SUB_IMM_ST}, 8);
      is_ret    = instr_valid && match(instr, {2'b00, OP_RETURN}, 7);
   end

   // operand steering into the alu
   always_comb begin
      au.op  = is_rot ? ALU_ROTATE : ALU_SUB;
      au.cin = carry_bit_r;
      au.lhs = mem_rdata;
      au.rhs = result_nibble_register_r;
      if (is_sub_i || is_sub_is) begin
         au.lhs = wreg_rdata;
         au.rhs = instr[IMM_LSB +: NIB_W];
      end
   end

   logic              alu_hit;
   logic              store_mem;
   logic              store_wreg;

   // instruction class, shared by the memory, register and state groups below
   always_comb begin
      alu_hit    = is_rot | is_sub_m | is_sub_ms | is_sub_i | is_sub_is;
      store_mem  = is_rot | is_sub_ms;
      store_wreg = is_sub_is;
   end

   logic              mem_we_nxt;
   logic [ADDR_W-1:0] mem_addr_nxt;
   logic [NIB_W-1:0]  mem_wdata_nxt;

   // memory port: address and data hold after the pulse, which
   // lets the environment forward a store that has not landed yet
   always_comb begin
      mem_we_nxt    = store_mem;
      mem_addr_nxt  = mem_addr_r;
      mem_wdata_nxt = mem_wdata_r;
      if (alu_hit) begin
         mem_addr_nxt  = instr[ADDR_W-1:0];
         mem_wdata_nxt = au.res;
      end
   end

   // memory port registers; the strobe is a one-cycle pulse
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mem_we_r    <= 1'b0;
         mem_addr_r  <= ADDR_RST;
         mem_wdata_r <= ACC_RST;
      end else begin
         mem_we_r    <= mem_we_nxt;
         mem_addr_r  <= mem_addr_nxt;
         mem_wdata_r <= mem_wdata_nxt;
      end
   end

   logic              wreg_we_nxt;
   logic [WSEL_W-1:0] wreg_sel_nxt;
   logic [NIB_W-1:0]  wreg_wdata_nxt;

   // working register port: only the store form raises the strobe
   always_comb begin
      wreg_we_nxt    = store_wreg;
      wreg_sel_nxt   = wreg_sel_r;
      wreg_wdata_nxt = wreg_wdata_r;
      if (alu_hit) begin
         wreg_sel_nxt   = instr[WSEL_LSB +: WSEL_W];
         wreg_wdata_nxt = au.res;
      end
   end

   // working register port registers
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wreg_we_r    <= 1'b0;
         wreg_sel_r   <= WSEL_RST;
         wreg_wdata_r <= ACC_RST;
      end else begin
         wreg_we_r    <= wreg_we_nxt;
         wreg_sel_r   <= wreg_sel_nxt;
         wreg_wdata_r <= wreg_wdata_nxt;
      end
   end

   logic              pc_load_nxt;
   logic [PC_W-1:0]   pc_value_nxt;

   // program counter: the stack top is taken as it stands in the
   // return cycle; the pop itself is left to the environment
   always_comb begin
      pc_load_nxt  = is_ret;
      pc_value_nxt = pc_value_r;
      if (is_ret) begin
         pc_value_nxt = stack_top;
      end
   end

   // program counter load registers
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pc_load_r  <= 1'b0;
         pc_value_r <= PC_RST;
      end else begin
         pc_load_r  <= pc_load_nxt;
         pc_value_r <= pc_value_nxt;
      end
   end

   logic [NIB_W-1:0]  acc_nxt;
   logic              carry_nxt;
   logic              zero_nxt;

   // architectural state: all alu forms land in the accumulator and
   // both flags; a return or a refused word holds them
   always_comb begin
      acc_nxt   = result_nibble_register_r;
      carry_nxt = carry_bit_r;
      zero_nxt  = zero_bit_r;
      if (alu_hit) begin
         acc_nxt   = au.res;
         carry_nxt = au.cout;
         zero_nxt  = au.zero;
      end
   end

   // architectural state registers
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         result_nibble_register_r <= ACC_RST;
         carry_bit_r              <= CARRY_RST;
         zero_bit_r               <= ZERO_RST;
      end else begin
         result_nibble_register_r <= acc_nxt;
         carry_bit_r              <= carry_nxt;
         zero_bit_r               <= zero_nxt;
      end
   end
endmodule

// [hdl/nibble_pkg.sv]
// shared constants for the rotate / subtract / return datapath
package nibble_pkg;
   localparam int NIB_W  = 4;
   localparam int ADDR_W = 7;
   localparam int PC_W   = 11;
   localparam int WSEL_W = 4;
   localparam int INSTR_W = 16;

   // opcode prefixes, left aligned in the instruction word
   localparam logic [8:0] OP_ROTATE_RIGHT = 9'h09b;  // 0100_1101_1
   localparam logic [8:0] OP_SUB_MEM      = 9'h014;  // 0000_1010_0
   localparam logic [8:0] OP_SUB_MEM_ST   = 9'h016;  // 0000_1011_0
   localparam logic [7:0] OP_SUB_IMM      = 8'h0e;   // 0000_1110
   localparam logic [7:0] OP_SUB_IMM_ST   = 8'h0f;   // 0000_1111
   localparam logic [6:0] OP_RETURN       = 7'h01;   // 0000_001

   // field positions
   localparam int IMM_LSB  = 4;
   localparam int WSEL_LSB = 0;

   // reset values
   localparam logic [3:0]  ACC_RST   = 4'h0;
   localparam logic        CARRY_RST = 1'b0;
   localparam logic        ZERO_RST  = 1'b0;
   localparam logic [10:0] PC_RST    = 11'h000;
   localparam logic [6:0]  ADDR_RST  = 7'h00;
   localparam logic [3:0]  WSEL_RST  = 4'h0;

   typedef enum logic [1:0] {
      ALU_ROTATE = 2'b00,
      ALU_SUB    = 2'b01
   } alu_op_t;
endpackage

// [hdl/alu_if.sv]
// operand / result bundle between the datapath and its nibble alu
`timescale 1ns/100ps
interface alu_if;
   import nibble_pkg::*;
   alu_op_t    op;
   logic [3:0] lhs;
   logic [3:0] rhs;
   logic       cin;
   logic [3:0] res;
   logic       cout;
   logic       zero;
   modport core (output op, lhs, rhs, cin, input res, cout, zero);
   modport unit (input op, lhs, rhs, cin, output res, cout, zero);
endinterface

// [hdl/nibble_alu.sv]
// combinational nibble alu: rotate right through carry, subtract with borrow
`timescale 1ns/100ps
module nibble_alu (
   alu_if.unit a
);
   import nibble_pkg::*;

   logic [4:0] diff;

   // borrow convention: cout high when lhs - rhs - cin goes negative
   always_comb begin
      diff   = {1'b0, a.lhs} - {1'b0, a.rhs} - {4'h0, a.cin};
      a.res  = diff[3:0];
      a.cout = diff[4];
      if (a.op == ALU_ROTATE) begin
         a.res  = {a.cin, a.lhs[3:1]};
         a.cout = a.lhs[0];
      end
      a.zero = (a.res == 4'h0);
   end
endmodule

// [sim/exec_env.sv]
// behavioural data memory, working registers and return stack
`timescale 1ns/100ps
module exec_env (
   // core side
   input  wire logic        sys_clk,
   input  wire logic [15:0] instr,
   input  wire logic        mem_we_r, wreg_we_r, pc_load_r,
   input  wire logic [6:0]  mem_addr_r,
   input  wire logic [3:0]  mem_wdata_r, wreg_sel_r, wreg_wdata_r,
   // read data
   output logic      [3:0]  mem_rdata, wreg_rdata,
   output logic      [10:0] stack_top
);
   logic [3:0] mem [128];
   logic [3:0] wr [16];
   logic [2:0] sp = 3'h0;
   // pending write forwarded: the store lands one edge after the strobe
   assign mem_rdata = (mem_we_r && mem_addr_r == instr[6:0]) ?
                      mem_wdata_r : mem[instr[6:0]];
   assign wreg_rdata = (wreg_we_r && wreg_sel_r == instr[3:0]) ?
                       wreg_wdata_r : wr[instr[3:0]];
   // a pop still pending is forwarded, so back-to-back returns unwind
   assign stack_top = {sp + 3'(pc_load_r), 8'ha5};
   // writes and stack pop
   always @(posedge sys_clk) begin
      if (mem_we_r) mem[mem_addr_r] <= mem_wdata_r;
      if (wreg_we_r) wr[wreg_sel_r] <= wreg_wdata_r;
      if (pc_load_r) sp <= sp + 3'h1;
   end
endmodule

// [sim/exec_chk_assertions.sv]
// concurrent checks on the datapath ports
`timescale 1ns/100ps
module exec_chk import nibble_pkg::*; (
   input wire logic        sys_clk, sys_rst, instr_valid,
   input wire logic [15:0] instr,
   input wire logic [3:0]  mem_rdata, wreg_rdata, mem_wdata_r,
   input wire logic [10:0] stack_top, pc_value_r,
   input wire logic        mem_we_r, wreg_we_r, pc_load_r,
   input wire logic [6:0]  mem_addr_r,
   input wire logic [3:0]  wreg_sel_r, wreg_wdata_r,
   input wire logic [3:0]  result_nibble_register_r,
   input wire logic        carry_bit_r, zero_bit_r
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   wire [8:0] p = instr_valid ? instr[15:7] : 9'h1ff;
   wire rot = p == OP_ROTATE_RIGHT;
   wire sub = p == OP_SUB_MEM || p == OP_SUB_MEM_ST ||
              p[8:1] == OP_SUB_IMM || p[8:1] == OP_SUB_IMM_ST;
   // instr[10] separates register subtract forms from memory subtract forms
   wire [4:0] df = {1'b0, instr[10] ? wreg_rdata : mem_rdata} -
      {1'b0, instr[10] ? instr[7:4] : result_nibble_register_r} -
      5'(carry_bit_r);
   wire [4:0] cr = {carry_bit_r, result_nibble_register_r};
   property p_rot; rot |=> cr == {$past(mem_rdata[0]),
      $past(carry_bit_r), $past(mem_rdata[3:1])}; endproperty
   a_rot: assert property (p_rot) else $error("rotate wrong");
   property p_rotw; rot |=> mem_we_r && mem_wdata_r ==
      result_nibble_register_r && mem_addr_r == $past(instr[6:0]);
   endproperty
   a_rotw: assert property (p_rotw) else $error("rotate store");
   property p_ret; p[8:2] == OP_RETURN |=> pc_load_r &&
      pc_value_r == $past(stack_top) ##1
      pc_load_r == ($past(p[8:2]) == OP_RETURN); endproperty
   a_ret: assert property (p_ret) else $error("return wrong");
   property p_sm; p == OP_SUB_MEM |=> cr == $past(df) && !mem_we_r;
   endproperty
   a_sm: assert property (p_sm) else $error("sub mem wrong");
   property p_si; p[8:1] == OP_SUB_IMM |=> cr == $past(df) && !wreg_we_r;
   endproperty
   a_si: assert property (p_si) else $error("sub imm wrong");
   property p_sms; p == OP_SUB_MEM_ST |=> cr == $past(df) && mem_we_r &&
      mem_wdata_r == result_nibble_register_r; endproperty
   a_sms: assert property (p_sms) else $error("sub mem store");
   property p_sis; p[8:1] == OP_SUB_IMM_ST |=> cr == $past(df) &&
      wreg_we_r && wreg_sel_r == $past(instr[3:0]); endproperty
   a_sis: assert property (p_sis) else $error("sub reg store");
   property p_z; rot || sub |=> zero_bit_r ==
      (result_nibble_register_r == 4'h0); endproperty
   a_z: assert property (p_z) else $error("zero flag wrong");
   property p_idle; !instr_valid |=> !mem_we_r && !wreg_we_r &&
      $stable(result_nibble_register_r); endproperty
   a_idle: assert property (p_idle) else $error("idle changed state");
   c_rot: cover property (rot ##1 rot);
   c_ret: cover property (p[8:2] == OP_RETURN ##1 p[8:2] == OP_RETURN);
   c_brw: cover property (sub ##1 carry_bit_r && zero_bit_r);
endmodule
bind nibble_exec exec_chk C (.*);

// [sim/tb.sv]
// self-checking bench for the rotate / subtract / return datapath
`timescale 1ns/100ps
module tb;
   import nibble_pkg::*;
   logic sys_clk = 0, sys_rst = 1, instr_valid = 0, rc = 0, rz = 0;
   logic [15:0] instr = 16'h0000, w;
   logic [3:0] sm [128], sw [16], racc = 4'h0;
   logic [2:0] rsp = 3'h0;
   logic [31:0] x;
   logic [6:0] a;
   wire [3:0] mem_rdata, wreg_rdata, mem_wdata_r, wreg_sel_r, wreg_wdata_r;
   wire [3:0] result_nibble_register_r;
   wire [10:0] stack_top, pc_value_r;
   wire [6:0] mem_addr_r;
   wire mem_we_r, wreg_we_r, pc_load_r, carry_bit_r, zero_bit_r;
   int fails = 0, num_checks = 0;
   nibble_exec DUT (.*);
   exec_env PM (.*);
   always #20 sys_clk = ~sys_clk;
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // drive one word at the falling edge, predict, look one cycle later
   task automatic run(logic [15:0] wd, logic v = 1'b1);
      logic [3:0] e;
      logic [8:0] q;
      logic [4:0] d;
      logic c, mw, ww, pl;
      e = racc; c = rc; mw = 0; ww = 0; q = v ? wd[15:7] : 9'h1ff;
      d = {1'b0, wd[10] ? sw[wd[3:0]] : sm[wd[6:0]]} -
          {1'b0, wd[10] ? wd[7:4] : racc} - 5'(rc);
      instr = wd; instr_valid = v;
      pl = q[8:2] == OP_RETURN;
      if (q == OP_ROTATE_RIGHT) {e, c} = {rc, sm[wd[6:0]]};
      if (q == OP_SUB_MEM || q == OP_SUB_MEM_ST || q[8:1] == OP_SUB_IMM ||
          q[8:1] == OP_SUB_IMM_ST) {c, e} = d;
      mw = q == OP_ROTATE_RIGHT || q == OP_SUB_MEM_ST;
      ww = q[8:1] == OP_SUB_IMM_ST;
      if (q == OP_ROTATE_RIGHT || q == OP_SUB_MEM || q == OP_SUB_MEM_ST ||
          q[8:1] == OP_SUB_IMM || q[8:1] == OP_SUB_IMM_ST) rz = e == 0;
      @(negedge sys_clk);
      chk("state", {5'h0, e, c, rz, mw, ww, pl}, {5'h0,
          result_nibble_register_r, carry_bit_r, zero_bit_r, mem_we_r,
          wreg_we_r, pc_load_r});
      if (pl) chk("pc", {5'h0, rsp, 8'ha5}, {5'h0, pc_value_r});
      rsp += 3'(pl);
      if (mw) sm[wd[6:0]] = e;
      if (ww) sw[wd[3:0]] = e;
      racc = e; rc = c;
   endtask
   initial begin
      #40_000 fails++;
      conclude();
   end
   initial begin
      x = $urandom(32'h07347e5b);
      for (int i = 0; i < 128; i++) begin
         sm[i] = 4'($urandom); PM.mem[i] = sm[i];
         if (i < 16) begin sw[i] = 4'($urandom); PM.wr[i] = sw[i]; end
      end
      repeat (4) @(negedge sys_clk);
      sys_rst = 0;
      chk("reset", 16'h0, {7'h0, result_nibble_register_r, carry_bit_r,
          zero_bit_r, mem_we_r, wreg_we_r, pc_load_r, pc_value_r[0]});
      run({OP_RETURN, 9'h1ff}); run({OP_RETURN, 9'h000});
      run({OP_SUB_IMM_ST, 8'hf3});
      run({OP_SUB_IMM, 8'h03});
      run({OP_ROTATE_RIGHT, 7'h7f});
      run({OP_SUB_MEM_ST, 7'h7f});
      run({OP_SUB_MEM, 7'h7f});
      run({OP_ROTATE_RIGHT, 7'h00}, 1'b0);
      repeat (300) begin
         x = $urandom;
         a = x[8] ? x[6:0] : {4'h0, x[2:0]};
         case (x[31:16] % 7)
            0: w = {OP_ROTATE_RIGHT, a};
            1: w = {OP_SUB_MEM, a};
            2: w = {OP_SUB_MEM_ST, a};
            3: w = {OP_SUB_IMM, x[7:0]};
            4: w = {OP_SUB_IMM_ST, x[7:0]};
            5: w = {OP_RETURN, x[8:0]};
            default: w = {2'b11, x[13:0]};
         endcase
         run(w, x[15] | x[14]);
      end
      instr_valid = 0;
      @(negedge sys_clk);
      conclude();
   end
endmodule
